// >>> rtl/tcap_regs.svh
`ifndef TCAP_REGS_SVH
`define TCAP_REGS_SVH
// Byte offsets of the register words
`define TCAP_OFF_CTRL_ONE   8'h00
`define TCAP_OFF_CTRL_TWO   8'h04
`define TCAP_OFF_FLAGS      8'h08
`define TCAP_OFF_CAP_A      8'h0c
`define TCAP_OFF_CAP_B      8'h10
`define TCAP_OFF_CMP_A      8'h14
`define TCAP_OFF_CMP_B      8'h18
`define TCAP_OFF_CNT        8'h1c
`define TCAP_OFF_ALT_CNT    8'h20
// Control one fields
`define TCAP_C1_IRQ_EN      7
`define TCAP_C1_EDGE_A      1
// Control two fields
`define TCAP_C2_PWM         5
`define TCAP_C2_ONE_PULSE   4
`define TCAP_C2_CLK_HI      3
`define TCAP_C2_CLK_LO      2
`define TCAP_C2_EDGE_B      1
// Flag register fields
`define TCAP_FL_CAP_A       7
`define TCAP_FL_MATCH_A     6
`define TCAP_FL_WRAP        5
`define TCAP_FL_CAP_B       4
`define TCAP_FL_MATCH_B     3
`define TCAP_FL_OFF         2
// Reset value and counter maximum
`define TCAP_RST_BYTE       8'h00
`define TCAP_CNT_MAX        8'hff
// Prescaler masks: tick when masked prescaler bits are all ones
`define TCAP_DIV4_MASK      3'h3
`define TCAP_DIV2_MASK      3'h1
`define TCAP_DIV8_MASK      3'h7
`define TCAP_DIV1_MASK      3'h0
`endif

// >>> rtl/tcap_pkg.sv
package tcap_pkg;
  // Timer clock selection codes
  typedef enum logic [1:0] {
    TCAP_CLK_DIV4,
    TCAP_CLK_DIV2,
    TCAP_CLK_DIV8,
    TCAP_CLK_DIV1
  } tcap_clk_e;
  typedef logic [7:0] tcap_byte_t;
endpackage : tcap_pkg

// >>> rtl/tcap_timer.sv
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "tcap_regs.svh"
// Summary of operation
// - Two capture registers latch counter on edges
// - Capture registers ignore software writes
// - Per-channel edge select bit picks polarity
// - Capture resolution is one counter step
// - Capture sets flag and loads counter value
// - Capture interrupt needs enable and unmasked CPU
// - One enable gates both capture channels
// - Flag clears: status read, then register access
// - Newest capture overwrites older value
// - One-pulse or PWM leaves only channel b
// - Capture pins always feed the timer
// - PWM compare b match also sets flag a
// - Match flags set on equality, sequence clears
// - Wrap flag sets on max to zero
// - Alternate counter access keeps wrap flag
// - Timer off freezes counter, releases compare pins
// - Flag layout bits 7..2, bits 1:0 zero
// - Flags reset zero, only timer off writable
module tcap_timer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        capture_pin_a,
  input  wire logic        capture_pin_b,
  input  wire logic        cpu_irq_mask,
  output logic             timer_irq,
  output logic             compare_pin_a,
  output logic             compare_pin_a_oe,
  output logic             compare_pin_b,
  output logic             compare_pin_b_oe
);

  // Address match helper, used by every decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  // Prescaler mask for a clock select code
  function automatic logic [2:0] div_mask(input logic [1:0] sel);
    unique case (tcap_pkg::tcap_clk_e'(sel))
      tcap_pkg::TCAP_CLK_DIV4: div_mask = `TCAP_DIV4_MASK;
      tcap_pkg::TCAP_CLK_DIV2: div_mask = `TCAP_DIV2_MASK;
      tcap_pkg::TCAP_CLK_DIV8: div_mask = `TCAP_DIV8_MASK;
      tcap_pkg::TCAP_CLK_DIV1: div_mask = `TCAP_DIV1_MASK;
    endcase
  endfunction : div_mask

  // Pin synchronisers, three stages each, plus settled level
  logic [2:0]           sync_a_r, sync_b_r;
  logic [2:0]           sync_a_nxt, sync_b_nxt;
  logic                 lvl_a_r, lvl_b_r;
  logic                 lvl_a_nxt, lvl_b_nxt;
  // Timer core state
  logic [2:0]           presc_r, presc_nxt;
  tcap_pkg::tcap_byte_t cnt_r, cnt_nxt;
  tcap_pkg::tcap_byte_t ctrl1_r, ctrl1_nxt;
  tcap_pkg::tcap_byte_t ctrl2_r, ctrl2_nxt;
  tcap_pkg::tcap_byte_t cap_a_r, cap_a_nxt;
  tcap_pkg::tcap_byte_t cap_b_r, cap_b_nxt;
  tcap_pkg::tcap_byte_t cmp_a_r, cmp_a_nxt;
  tcap_pkg::tcap_byte_t cmp_b_r, cmp_b_nxt;
  // Flags, their clear arming bits and the disable bit
  logic [4:0]           flag_r, flag_nxt;
  logic [4:0]           arm_r, arm_nxt;
  logic                 off_r, off_nxt;
  logic [31:0]          rdata_r, rdata_nxt;

  // Decoded strobes and events
  logic acc, wr, rd, setup;
  logic tick, wrap_ev, match_a_ev, match_b_ev;
  logic edge_a, edge_b, cap_a_ev, cap_b_ev, pwm_mode, solo_b;
  logic acc_flags, acc_cap_a, acc_cap_b, acc_cmp_a, acc_cmp_b;
  logic acc_cnt, acc_alt, mapped;
  logic [4:0] set_v, clr_v;
  tcap_pkg::tcap_byte_t flags_byte;

  // Flag index inside flag_r, in status bit order
  localparam int FI_CAP_A   = 4;
  localparam int FI_MATCH_A = 3;
  localparam int FI_WRAP    = 2;
  localparam int FI_CAP_B   = 1;
  localparam int FI_MATCH_B = 0;

  // Zero-wait slave: every access phase completes at once
  assign pready = 1'b1;
  assign acc    = psel & penable;
  assign setup  = psel & ~penable;
  assign wr     = acc & pwrite;
  assign rd     = acc & ~pwrite;

  // Register decode
  assign acc_flags = acc & hit(paddr, `TCAP_OFF_FLAGS);
  assign acc_cap_a = acc & hit(paddr, `TCAP_OFF_CAP_A);
  assign acc_cap_b = acc & hit(paddr, `TCAP_OFF_CAP_B);
  assign acc_cmp_a = acc & hit(paddr, `TCAP_OFF_CMP_A);
  assign acc_cmp_b = acc & hit(paddr, `TCAP_OFF_CMP_B);
  assign acc_cnt   = acc & hit(paddr, `TCAP_OFF_CNT);
  assign acc_alt   = acc & hit(paddr, `TCAP_OFF_ALT_CNT);
  assign mapped = hit(paddr, `TCAP_OFF_CTRL_ONE) |
                  hit(paddr, `TCAP_OFF_CTRL_TWO) |
                  hit(paddr, `TCAP_OFF_FLAGS)    |
                  hit(paddr, `TCAP_OFF_CAP_A)    |
                  hit(paddr, `TCAP_OFF_CAP_B)    |
                  hit(paddr, `TCAP_OFF_CMP_A)    |
                  hit(paddr, `TCAP_OFF_CMP_B)    |
                  hit(paddr, `TCAP_OFF_CNT)      |
                  hit(paddr, `TCAP_OFF_ALT_CNT);
  // Unmapped words answer with an error, reads give zero
  assign pslverr = acc & ~mapped;
  assign prdata  = rdata_r;

  // Divided tick; frozen while the timer is off
  assign tick = ~off_r &
    ((presc_r & div_mask(ctrl2_r[`TCAP_C2_CLK_HI:`TCAP_C2_CLK_LO])) ==
     div_mask(ctrl2_r[`TCAP_C2_CLK_HI:`TCAP_C2_CLK_LO]));
  assign wrap_ev    = tick & (cnt_r == `TCAP_CNT_MAX);
  // Match is judged on the value the counter steps into
  assign match_a_ev = tick & (cnt_r + 8'h01 == cmp_a_r);
  assign match_b_ev = tick & (cnt_r + 8'h01 == cmp_b_r);

  // Edge detect on the settled level; polarity per channel
  // Pulses shorter than two stages never reach the settled level
  assign edge_a = (sync_a_r[1] == sync_a_r[2]) &
    (sync_a_r[2] != lvl_a_r) &
    (sync_a_r[2] == ctrl1_r[`TCAP_C1_EDGE_A]);
  assign edge_b = (sync_b_r[1] == sync_b_r[2]) &
    (sync_b_r[2] != lvl_b_r) &
    (sync_b_r[2] == ctrl2_r[`TCAP_C2_EDGE_B]);
  assign pwm_mode = ctrl2_r[`TCAP_C2_PWM];
  assign solo_b   = pwm_mode | ctrl2_r[`TCAP_C2_ONE_PULSE];
  assign cap_a_ev = edge_a & ~solo_b;
  assign cap_b_ev = edge_b;

  // Set vector; PWM compare b also raises capture flag a
  assign set_v[FI_CAP_A]   = cap_a_ev | (pwm_mode & match_b_ev);
  assign set_v[FI_MATCH_A] = match_a_ev;
  assign set_v[FI_WRAP]    = wrap_ev;
  assign set_v[FI_CAP_B]   = cap_b_ev;
  assign set_v[FI_MATCH_B] = match_b_ev;
  // Clear needs a prior status read; alt counter never clears
  assign clr_v[FI_CAP_A]   = arm_r[FI_CAP_A]   & acc_cap_a;
  assign clr_v[FI_MATCH_A] = arm_r[FI_MATCH_A] & acc_cmp_a;
  assign clr_v[FI_WRAP]    = arm_r[FI_WRAP]    & acc_cnt;
  assign clr_v[FI_CAP_B]   = arm_r[FI_CAP_B]   & acc_cap_b;
  assign clr_v[FI_MATCH_B] = arm_r[FI_MATCH_B] & acc_cmp_b;

  // Status byte image, low two bits fixed at zero
  assign flags_byte = {flag_r, off_r, 2'b00};

  // Shared enable, CPU mask; pending flags wait for both
  assign timer_irq = ctrl1_r[`TCAP_C1_IRQ_EN] & ~cpu_irq_mask &
                     (flag_r[FI_CAP_A] | flag_r[FI_CAP_B]);

  // Compare pins follow their match flags, released while off
  assign compare_pin_a    = flag_r[FI_MATCH_A];
  assign compare_pin_b    = flag_r[FI_MATCH_B];
  assign compare_pin_a_oe = ~off_r;
  assign compare_pin_b_oe = ~off_r;

  // Next-state logic for the whole block
  always_comb begin
    sync_a_nxt = {sync_a_r[1:0], capture_pin_a};
    sync_b_nxt = {sync_b_r[1:0], capture_pin_b};
    // Settled level moves only once stages two and three agree
    lvl_a_nxt = (sync_a_r[1] == sync_a_r[2]) ? sync_a_r[2] : lvl_a_r;
    lvl_b_nxt = (sync_b_r[1] == sync_b_r[2]) ? sync_b_r[2] : lvl_b_r;
    presc_nxt = off_r ? presc_r : presc_r + 3'h1;
    cnt_nxt   = tick ? cnt_r + 8'h01 : cnt_r;
    // Counter write of either alias resets it, even when off
    // The prescaler restarts too, so the first step is a full period
    if (wr & (acc_cnt | acc_alt)) begin
      cnt_nxt   = `TCAP_RST_BYTE;
      presc_nxt = 3'h0;
    end
    ctrl1_nxt = ctrl1_r;
    ctrl2_nxt = ctrl2_r;
    cmp_a_nxt = cmp_a_r;
    cmp_b_nxt = cmp_b_r;
    off_nxt   = off_r;
    if (wr & hit(paddr, `TCAP_OFF_CTRL_ONE)) begin
      ctrl1_nxt = pwdata[7:0];
    end
    if (wr & hit(paddr, `TCAP_OFF_CTRL_TWO)) begin
      ctrl2_nxt = pwdata[7:0];
    end
    if (wr & acc_cmp_a) begin
      cmp_a_nxt = pwdata[7:0];
    end
    if (wr & acc_cmp_b) begin
      cmp_b_nxt = pwdata[7:0];
    end
    // Only the disable bit of the status word takes writes
    if (wr & acc_flags) begin
      off_nxt = pwdata[`TCAP_FL_OFF];
    end
    // Captures take the counter; software writes never land
    cap_a_nxt = cap_a_ev ? cnt_r : cap_a_r;
    cap_b_nxt = cap_b_ev ? cnt_r : cap_b_r;
    // Set wins over clear in the same cycle
    flag_nxt = (flag_r & ~clr_v) | set_v;
    // A status read arms the flags it saw set
    arm_nxt = arm_r & ~clr_v;
    if (rd & acc_flags) begin
      arm_nxt = arm_r | flag_r;
    end
    // Read data is captured in the setup cycle
    // so a zero-wait access phase already finds it standing
    rdata_nxt = rdata_r;
    if (setup & ~pwrite) begin
      rdata_nxt = 32'h0000_0000;
      if (hit(paddr, `TCAP_OFF_CTRL_ONE)) begin
        rdata_nxt[7:0] = ctrl1_r;
      end else if (hit(paddr, `TCAP_OFF_CTRL_TWO)) begin
        rdata_nxt[7:0] = ctrl2_r;
      end else if (hit(paddr, `TCAP_OFF_FLAGS)) begin
        rdata_nxt[7:0] = flags_byte;
      end else if (hit(paddr, `TCAP_OFF_CAP_A)) begin
        rdata_nxt[7:0] = cap_a_r;
      end else if (hit(paddr, `TCAP_OFF_CAP_B)) begin
        rdata_nxt[7:0] = cap_b_r;
      end else if (hit(paddr, `TCAP_OFF_CMP_A)) begin
        rdata_nxt[7:0] = cmp_a_r;
      end else if (hit(paddr, `TCAP_OFF_CMP_B)) begin
        rdata_nxt[7:0] = cmp_b_r;
      end else if (hit(paddr, `TCAP_OFF_CNT) |
                   hit(paddr, `TCAP_OFF_ALT_CNT)) begin
        rdata_nxt[7:0] = cnt_r;
      end
    end
  end

  // State registers; reset clears every flag and field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a_r <= 3'h0;
      sync_b_r <= 3'h0;
      lvl_a_r  <= 1'b0;
      lvl_b_r  <= 1'b0;
      presc_r  <= 3'h0;
      cnt_r    <= `TCAP_RST_BYTE;
      ctrl1_r  <= `TCAP_RST_BYTE;
      ctrl2_r  <= `TCAP_RST_BYTE;
      cap_a_r  <= `TCAP_RST_BYTE;
      cap_b_r  <= `TCAP_RST_BYTE;
      cmp_a_r  <= `TCAP_RST_BYTE;
      cmp_b_r  <= `TCAP_RST_BYTE;
      flag_r   <= 5'h00;
      arm_r    <= 5'h00;
      off_r    <= 1'b0;
      rdata_r  <= 32'h0000_0000;
    end else begin
      sync_a_r <= sync_a_nxt;
      sync_b_r <= sync_b_nxt;
      lvl_a_r  <= lvl_a_nxt;
      lvl_b_r  <= lvl_b_nxt;
      presc_r  <= presc_nxt;
      cnt_r    <= cnt_nxt;
      ctrl1_r  <= ctrl1_nxt;
      ctrl2_r  <= ctrl2_nxt;
      cap_a_r  <= cap_a_nxt;
      cap_b_r  <= cap_b_nxt;
      cmp_a_r  <= cmp_a_nxt;
      cmp_b_r  <= cmp_b_nxt;
      flag_r   <= flag_nxt;
      arm_r    <= arm_nxt;
      off_r    <= off_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  // Checks on the design's own behaviour
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_cap_a_load: assert property (cap_a_ev |=>
    (cap_a_r == $past(cnt_r)) && flag_r[FI_CAP_A])
    else $error("capture a did not load counter and flag");
  a_cap_b_ro: assert property ((wr && acc_cap_b && !cap_b_ev) |=>
    $stable(cap_b_r))
    else $error("capture b changed on a software write");
  a_irq_gate: assert property (timer_irq |->
    (!cpu_irq_mask && ctrl1_r[`TCAP_C1_IRQ_EN]))
    else $error("interrupt raised while gated");
  a_solo_b: assert property ((solo_b && edge_a) |=>
    $stable(cap_a_r))
    else $error("channel a captured in pwm or one pulse");
  a_wrap_set: assert property (wrap_ev |=>
    flag_r[FI_WRAP] && (cnt_r == `TCAP_RST_BYTE))
    else $error("wrap did not set flag or zero counter");
  a_alt_keeps: assert property ((acc_alt && flag_r[FI_WRAP]) |=>
    flag_r[FI_WRAP])
    else $error("alternate counter access cleared wrap flag");
  a_off_freeze: assert property ((off_r &&
    !(wr && (acc_flags || acc_cnt || acc_alt))) |=>
    $stable(cnt_r) && !compare_pin_a_oe && !compare_pin_b_oe)
    else $error("counter moved or pins driven while timer off");
  a_clear_seq: assert property ((acc_cap_a && !arm_r[FI_CAP_A] &&
    flag_r[FI_CAP_A]) |=> flag_r[FI_CAP_A])
    else $error("capture flag cleared without status read");
  a_flags_low: assert property ((setup && !pwrite &&
    hit(paddr, `TCAP_OFF_FLAGS)) |=> (prdata[1:0] == 2'b00))
    else $error("reserved status bits read nonzero");

  // Flag set, clear and interrupt paths
  a_match_set: assert property (match_a_ev |=>
    flag_r[FI_MATCH_A] && compare_pin_a)
    else $error("compare a match did not set its flag");

  a_pwm_flag: assert property ((pwm_mode && match_b_ev) |=>
    flag_r[FI_CAP_A])
    else $error("pwm compare b match missed capture flag a");

  a_wrap_clear: assert property ((acc_cnt && arm_r[FI_WRAP] &&
    !wrap_ev) |=> !flag_r[FI_WRAP])
    else $error("wrap flag survived its clear sequence");

  a_cap_clear: assert property ((acc_cap_b && arm_r[FI_CAP_B] &&
    !cap_b_ev) |=> !flag_r[FI_CAP_B])
    else $error("capture flag b survived its clear sequence");

  a_irq_shared: assert property ((cap_b_ev &&
    ctrl1_r[`TCAP_C1_IRQ_EN] && !wr) |=> (timer_irq || cpu_irq_mask))
    else $error("channel b capture did not request the interrupt");

  a_status_ro: assert property ((wr && acc_flags) |=>
    flag_r == ($past(flag_r) | $past(set_v)))
    else $error("status write changed a flag bit");

endmodule : tcap_timer

// >>> tb/tcap_pin_src.sv
`timescale 1ns/10ps
// External source for the two capture pins
module tcap_pin_src (
  input  wire logic pclk,
  output logic      pin_a,
  output logic      pin_b
);
  // Both pins idle low until a scenario moves them
  initial begin
    pin_a = 1'h0;
    pin_b = 1'h0;
  end
  // Pins only ever feed the timer; never driven back by the device
  task automatic drive(input logic sel_b, input logic lvl);
    @(posedge pclk);
    if (sel_b) begin
      pin_b <= lvl;
    end else begin
      pin_a <= lvl;
    end
  endtask : drive
endmodule : tcap_pin_src

// >>> tb/timer8_input_capture_status_tb.sv
`timescale 1ns/10ps
`include "tcap_regs.svh"
module timer8_input_capture_status_tb;
  typedef struct {
    logic [7:0]  a;
    logic [31:0] d;
    logic        e;
  } tcap_row_s;
  logic        pclk, presetn, psel, penable, pwrite, cpu_irq_mask;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, v, v2;
  logic        pready, pslverr, err, timer_irq;
  logic        cp_a, cp_a_oe, cp_b, cp_b_oe, pin_a, pin_b;
  int          fails, compares;
  tcap_row_s   rows [8]; // Reset view of seven mapped words, counters left out, one unmapped
  // Free-running 40 MHz clock
  initial pclk = 1'h0;
  always #12.5 pclk = ~pclk;
  tcap_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_pin_a(pin_a), .capture_pin_b(pin_b),
    .cpu_irq_mask(cpu_irq_mask), .timer_irq(timer_irq),
    .compare_pin_a(cp_a), .compare_pin_a_oe(cp_a_oe),
    .compare_pin_b(cp_b), .compare_pin_b_oe(cp_b_oe));
  tcap_pin_src src (.pclk(pclk), .pin_a(pin_a), .pin_b(pin_b));
  // Verdict and end of run
  task automatic complete_run;
    $display("Counts: %0d compares, %0d fails", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  // Case-equality compare so an unknown never matches
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    // A stuck slave ends the run as a failure
    if (n >= 50) begin
      fails++;
      complete_run();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  // Read a word and compare it
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc
  // Freeze or release the timer, keeping the flags untouched
  task automatic off(input logic o);
    apb(1'h1, `TCAP_OFF_FLAGS, o ? 32'h04 : 32'h00);
  endtask : off
  // Main sequence
  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cpu_irq_mask = 1'h0;
    rows = '{'{8'h00, 32'h0, 1'h0}, '{8'h04, 32'h0, 1'h0},
             '{8'h08, 32'h0, 1'h0}, '{8'h0c, 32'h0, 1'h0},
             '{8'h10, 32'h0, 1'h0}, '{8'h14, 32'h0, 1'h0},
             '{8'h18, 32'h0, 1'h0}, '{8'h24, 32'h0, 1'h1}};
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    foreach (rows[i]) begin
      rdc(rows[i].a, rows[i].d);
      chk(err, rows[i].e);
    end
    chk({cp_a_oe, cp_b_oe, timer_irq}, 3'h6);
    $display("Test reset table done");
    // Only the disable bit is writable; bits 1:0 read zero
    apb(1'h1, `TCAP_OFF_FLAGS, 32'hff);
    rdc(`TCAP_OFF_FLAGS, 32'h04);
    chk({cp_a_oe, cp_b_oe}, 2'h0);
    apb(1'h1, `TCAP_OFF_CNT, 32'h0);
    apb(1'h1, `TCAP_OFF_CMP_A, 32'h80);
    apb(1'h1, `TCAP_OFF_CMP_B, 32'hc0);
    repeat (20) @(posedge pclk);
    rdc(`TCAP_OFF_CNT, 32'h0);
    $display("Test freeze done");
    // Capture on rising edge of pin a with counter frozen at v
    apb(1'h1, `TCAP_OFF_CTRL_ONE, 32'h02);
    apb(1'h1, `TCAP_OFF_CTRL_TWO, 32'h0e);
    off(1'h0);
    repeat (37) @(posedge pclk);
    off(1'h1);
    apb(1'h0, `TCAP_OFF_CNT, 32'h0);
    v = rd;
    src.drive(1'h0, 1'h1);
    repeat (6) @(posedge pclk);
    rdc(`TCAP_OFF_CAP_A, v);
    rdc(`TCAP_OFF_FLAGS, 32'h84);
    chk(timer_irq, 1'h0);
    rdc(`TCAP_OFF_CAP_A, v);
    rdc(`TCAP_OFF_FLAGS, 32'h04);
    // Falling edge selected, enable set, mask honoured
    apb(1'h1, `TCAP_OFF_CTRL_ONE, 32'h80);
    src.drive(1'h0, 1'h0);
    repeat (6) @(posedge pclk);
    chk(timer_irq, 1'h1);
    cpu_irq_mask <= 1'h1;
    @(negedge pclk);
    chk(timer_irq, 1'h0);
    @(posedge pclk);
    cpu_irq_mask <= 1'h0;
    rdc(`TCAP_OFF_FLAGS, 32'h84);
    apb(1'h1, `TCAP_OFF_CAP_A, 32'h55);
    rdc(`TCAP_OFF_CAP_A, v);
    rdc(`TCAP_OFF_FLAGS, 32'h04);
    src.drive(1'h0, 1'h1);
    repeat (6) @(posedge pclk);
    rdc(`TCAP_OFF_FLAGS, 32'h04);
    $display("Test capture a done");
    // Channel b raises the shared request; a newer capture overwrites
    off(1'h0);
    repeat (20) @(posedge pclk);
    off(1'h1);
    apb(1'h0, `TCAP_OFF_CNT, 32'h0);
    v2 = rd;
    src.drive(1'h1, 1'h1);
    repeat (6) @(posedge pclk);
    chk(timer_irq, 1'h1);
    src.drive(1'h0, 1'h0);
    repeat (6) @(posedge pclk);
    rdc(`TCAP_OFF_CAP_B, v2);
    rdc(`TCAP_OFF_CAP_A, v2);
    rdc(`TCAP_OFF_FLAGS, 32'h94);
    rdc(`TCAP_OFF_CAP_A, v2);
    rdc(`TCAP_OFF_CAP_B, v2);
    rdc(`TCAP_OFF_FLAGS, 32'h04);
    chk(timer_irq, 1'h0);
    $display("Test capture b done");
    // Full counter lap: wrap and both matches
    apb(1'h1, `TCAP_OFF_CTRL_ONE, 32'h00);
    off(1'h0);
    repeat (300) @(posedge pclk);
    off(1'h1);
    rdc(`TCAP_OFF_FLAGS, 32'h6c);
    chk({cp_a, cp_b}, 2'h3);
    apb(1'h0, `TCAP_OFF_ALT_CNT, 32'h0);
    rdc(`TCAP_OFF_FLAGS, 32'h6c);
    apb(1'h0, `TCAP_OFF_CNT, 32'h0);
    apb(1'h1, `TCAP_OFF_CMP_A, 32'h80);
    rdc(`TCAP_OFF_FLAGS, 32'h0c);
    $display("Test wrap and match done");
    // PWM: compare b sets capture flag a, pin a no longer captures
    apb(1'h1, `TCAP_OFF_CTRL_TWO, 32'h2e);
    off(1'h0);
    // Each level outlasts the synchroniser so the edge is real
    src.drive(1'h0, 1'h1);
    repeat (6) @(posedge pclk);
    src.drive(1'h0, 1'h0);
    repeat (6) @(posedge pclk);
    repeat (300) @(posedge pclk);
    off(1'h1);
    rdc(`TCAP_OFF_CAP_A, v2);
    apb(1'h0, `TCAP_OFF_FLAGS, 32'h0);
    chk(rd & 32'h80, 32'h80);
    $display("Test pwm done");
    // Divide by eight: 36 running clocks give four counter steps
    apb(1'h1, `TCAP_OFF_CTRL_TWO, 32'h08);
    off(1'h0);
    apb(1'h1, `TCAP_OFF_CNT, 32'h0);
    repeat (33) @(posedge pclk);
    off(1'h1);
    rdc(`TCAP_OFF_CNT, 32'h04);
    $display("Test rate done");
    // Reset in mid-run clears every flag, the disable bit and captures
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    rdc(`TCAP_OFF_FLAGS, 32'h00);
    chk({cp_a_oe, cp_b_oe, timer_irq}, 3'h6);
    rdc(`TCAP_OFF_CAP_A, 32'h00);
    $display("Test mid-run reset done");
    complete_run();
  end
endmodule : timer8_input_capture_status_tb
